// [rtc_weekday_and_control_tb.sv]
`timescale 1ns/1ps
`include "rtc_wkday_cfg.svh"

module rtc_weekday_and_control_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk_sys;
  logic rst_n;
  rwc_pkg::rwc_apb_req_type req;
  rwc_pkg::rwc_apb_rsp_type rsp;
  logic countTick;
  logic hourCarry;
  logic runEnable;
  logic softClear;
  logic dayCarry;
  logic [31:0] rdata;
  logic slvErr;
  int error_cnt = 0;
  int checks = 0;
  int dayCnt = 0;
  int cyc = 0;

  rwc_weekday_ctrl dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .apbReq(req),
    .apbRsp(rsp),
    .countTick(countTick),
    .hourCarry(hourCarry),
    .runEnable(runEnable),
    .softClear(softClear),
    .dayCarry(dayCarry)
  );

  // clock at 25 ns
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // count daily carry pulses and cut a hang short
  always @(posedge clk_sys) begin
    if (dayCarry === 1'b1) dayCnt++;
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do @(posedge clk_sys); while (rsp.pready !== 1'b1);
    rdata = rsp.prdata;
    slvErr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // one-cycle pulse on carry (c=1) or tick (c=0), then n idle cycles
  task automatic pulse(input bit c, input int n);
    @(posedge clk_sys);
    if (c) hourCarry <= 1'b1;
    else countTick <= 1'b1;
    @(posedge clk_sys);
    hourCarry <= 1'b0;
    countTick <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, `RWC_OFF_CTRL, 32'h0000_0000);
    chk(rdata, 32'h0000_0000, "ctrl reset");
    chk(slvErr, 1'b0, "mapped no error");
    apb(1'b0, `RWC_OFF_WKDAY, 32'h0000_0000);
    chk(rdata, 32'h0000_0000, "day reset");
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk(rdata, 32'h0000_0000, "unmapped data");
    chk(slvErr, 1'b1, "unmapped error");
  endtask

  task automatic t_fields();
    apb(1'b1, `RWC_OFF_WKDAY, 32'h0000_00fe);
    apb(1'b0, `RWC_OFF_WKDAY, 32'h0000_0000);
    chk(rdata, 32'h0000_0006, "day reserved bits");
    apb(1'b1, `RWC_OFF_WKDAY, 32'h0000_0007);
    apb(1'b0, `RWC_OFF_WKDAY, 32'h0000_0000);
    chk(rdata, 32'h0000_0006, "day code 7 kept");
    apb(1'b1, `RWC_OFF_CTRL, 32'h0000_00c7);
    apb(1'b0, `RWC_OFF_CTRL, 32'h0000_0000);
    chk(rdata, 32'h0000_00c0, "ctrl reserved bits");
    chk(runEnable, 1'b1, "run out");
  endtask

  task automatic t_day24();
    int base;
    base = dayCnt;
    for (int d = 0; d < 7; d++) begin
      apb(1'b1, `RWC_OFF_WKDAY, d);
      apb(1'b1, `RWC_OFF_HOUR, 32'h0000_0023);
      pulse(1'b1, 3);
      apb(1'b0, `RWC_OFF_HOUR, 32'h0000_0000);
      chk(rdata, 32'h0000_0000, "24h wrap");
      apb(1'b0, `RWC_OFF_WKDAY, 32'h0000_0000);
      chk(rdata, (d == 6) ? 32'h0000_0000 : d + 1, "day step");
    end
    chk(dayCnt - base, 7, "day carry count");
    apb(1'b1, `RWC_OFF_HOUR, 32'h0000_0011);
    pulse(1'b1, 3);
    apb(1'b0, `RWC_OFF_HOUR, 32'h0000_0000);
    chk(rdata, 32'h0000_0012, "24h passes 11");
    apb(1'b1, `RWC_OFF_HOUR, 32'h0000_0019);
    pulse(1'b1, 3);
    apb(1'b0, `RWC_OFF_HOUR, 32'h0000_0000);
    chk(rdata, 32'h0000_0020, "bcd tens carry");
  endtask

  task automatic t_h12();
    apb(1'b1, `RWC_OFF_CTRL, 32'h0000_0080);
    apb(1'b1, `RWC_OFF_WKDAY, 32'h0000_0002);
    apb(1'b1, `RWC_OFF_HOUR, 32'h0000_0011);
    pulse(1'b1, 3);
    apb(1'b0, `RWC_OFF_HOUR, 32'h0000_0000);
    chk(rdata, 32'h0000_0000, "12h wrap");
    apb(1'b0, `RWC_OFF_CTRL, 32'h0000_0000);
    chk(rdata, 32'h0000_00a0, "afternoon set");
    apb(1'b0, `RWC_OFF_WKDAY, 32'h0000_0000);
    chk(rdata, 32'h0000_0002, "no day at noon");
    pulse(1'b1, 3);
    apb(1'b0, `RWC_OFF_HOUR, 32'h0000_0000);
    chk(rdata, 32'h0000_0001, "12h step");
    apb(1'b1, `RWC_OFF_HOUR, 32'h0000_0011);
    pulse(1'b1, 3);
    apb(1'b0, `RWC_OFF_CTRL, 32'h0000_0000);
    chk(rdata, 32'h0000_0080, "afternoon clear");
    apb(1'b0, `RWC_OFF_WKDAY, 32'h0000_0000);
    chk(rdata, 32'h0000_0003, "day at midnight");
  endtask

  task automatic t_stop();
    apb(1'b1, `RWC_OFF_CTRL, 32'h0000_0040);
    @(negedge clk_sys);
    chk(runEnable, 1'b0, "run low");
    apb(1'b1, `RWC_OFF_HOUR, 32'h0000_0005);
    pulse(1'b1, 3);
    pulse(1'b0, 0);
    apb(1'b0, `RWC_OFF_HOUR, 32'h0000_0000);
    chk(rdata, 32'h0000_0005, "hold when stopped");
    apb(1'b0, `RWC_OFF_WKDAY, 32'h0000_0000);
    chk(rdata, 32'h0000_0003, "no busy stopped");
  endtask

  task automatic t_busy();
    apb(1'b1, `RWC_OFF_CTRL, 32'h0000_00c0);
    pulse(1'b0, 0);
    apb(1'b0, `RWC_OFF_WKDAY, 32'h0000_0000);
    chk(rdata, 32'h0000_0083, "busy set");
    repeat (8) @(posedge clk_sys);
    apb(1'b0, `RWC_OFF_WKDAY, 32'h0000_0000);
    chk(rdata, 32'h0000_0003, "busy ends");
  endtask

  task automatic t_clear();
    apb(1'b1, `RWC_OFF_HOUR, 32'h0000_0015);
    apb(1'b1, `RWC_OFF_CTRL, 32'h0000_00d0);
    repeat (2) @(negedge clk_sys);
    chk({runEnable, softClear}, 2'b01, "clear out");
    apb(1'b0, `RWC_OFF_CTRL, 32'h0000_0000);
    chk(rdata, 32'h0000_0010, "ctrl cleared");
    apb(1'b0, `RWC_OFF_WKDAY, 32'h0000_0000);
    chk(rdata, 32'h0000_0000, "day cleared");
    apb(1'b1, `RWC_OFF_HOUR, 32'h0000_0007);
    apb(1'b0, `RWC_OFF_HOUR, 32'h0000_0000);
    chk(rdata, 32'h0000_0000, "hour held clear");
    apb(1'b1, `RWC_OFF_CTRL, 32'h0000_0000);
    @(negedge clk_sys);
    chk(softClear, 1'b0, "clear released");
    apb(1'b1, `RWC_OFF_HOUR, 32'h0000_0007);
    apb(1'b0, `RWC_OFF_HOUR, 32'h0000_0000);
    chk(rdata, 32'h0000_0007, "normal again");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    req = '0;
    countTick = 1'b0;
    hourCarry = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_fields();
    t_day24();
    t_h12();
    t_stop();
    t_busy();
    t_clear();
    end_sim();
  end
endmodule

// [rtc_wkday_cfg.svh]
`ifndef RTC_WKDAY_CFG_SVH
`define RTC_WKDAY_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define RWC_OFF_HOUR 8'h00
`define RWC_OFF_WKDAY 8'h04
`define RWC_OFF_CTRL 8'h08

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RWC_WK_BUSY 7
`define RWC_CR_RUN 7
`define RWC_CR_FMT 6
`define RWC_CR_PM 5
`define RWC_CR_CLR 4
`define RWC_CR_RSV 3

// ----------------------------------------------------------------
// codes and limits
// ----------------------------------------------------------------
`define RWC_DAY_LAST 3'h6
`define RWC_DAY_BAD 3'h7
`define RWC_ONES_LAST 4'h9
`define RWC_TENS_LAST 2'h2
`define RWC_H12_LAST 6'h11
`define RWC_H24_LAST 6'h23
`define RWC_RST_HOUR 6'h00
`define RWC_RST_DAY 3'h0
`define RWC_BUSY_CYC 4'h4

`endif

// [rtc_wkday_ctrl.sv]
`timescale 1ns/1ps
`include "rtc_wkday_cfg.svh"

// Function
// - weekday advances by one on each daily carry from the hour count
// - weekday count only holds values zero through six
// - busy flag, weekday bit 7, is high while counters are updating
// - weekday bits 6 to 3 and control bits 2 to 0 read zero
// - weekday codes 000 Sunday to 110 Saturday; code 111 not written
// - run bit 7 starts counting when one, stops when zero
// - format bit zero gives 12-hour mode, hour counts 0 to 11
// - format bit one gives 24-hour mode, hour counts 0 to 23
// - afternoon flag bit 5 reads zero morning, one afternoon in 12-hour mode
// - clear bit 4 initialises all registers except itself
// - 12-hour wrap after eleven sets afternoon flag, next wrap clears it
// - hour tens digit counts zero through two in bcd
// - undefined counter and control fields become zero after a clear

module rwc_weekday_ctrl #(
  parameter logic [3:0] BUSY_CYC = `RWC_BUSY_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire rwc_pkg::rwc_apb_req_type apbReq,
  output rwc_pkg::rwc_apb_rsp_type apbRsp,
  input wire logic countTick,
  input wire logic hourCarry,
  output logic runEnable,
  output logic softClear,
  output logic dayCarry
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rwc_pkg::rwc_hour_type hour;
  rwc_pkg::rwc_hour_type next_hour;
  logic [2:0] weekday;
  logic runBit;
  logic fmt24;
  logic pmFlag;
  logic clearBit;
  logic rsvBit;
  logic busy;
  logic [3:0] busyCnt;
  logic [31:0] rdData;
  logic next_pm;
  logic wrapDay;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic setup;
  logic access;
  logic wrEn;
  logic hitHour;
  logic hitWkday;
  logic hitCtrl;
  logic hit;
  logic hourStep;

  // address match for the three words
  always_comb begin
    hitHour = 1'b0;
    hitWkday = 1'b0;
    hitCtrl = 1'b0;
    if (apbReq.paddr == `RWC_OFF_HOUR) begin
      hitHour = 1'b1;
    end else if (apbReq.paddr == `RWC_OFF_WKDAY) begin
      hitWkday = 1'b1;
    end else if (apbReq.paddr == `RWC_OFF_CTRL) begin
      hitCtrl = 1'b1;
    end
  end

  // phases of a transfer; slave never inserts wait states
  assign setup = apbReq.psel & ~apbReq.penable;
  assign access = apbReq.psel & apbReq.penable;
  assign hit = hitHour | hitWkday | hitCtrl;
  assign wrEn = access & apbReq.pwrite & hit;

  // answer: ready in every access cycle, error on unmapped address
  assign apbRsp = '{
    pready: access,
    pslverr: access & ~hit,
    prdata: rdData
  };

  // hourly step only while running and not held in clear
  assign hourStep = hourCarry & runBit & ~clearBit;

  // ----------------------------------------------------------------
  // hour count and afternoon flag
  // ----------------------------------------------------------------
  // next hour in bcd, wrapping per selected format
  always_comb begin
    next_hour = hour;
    next_pm = pmFlag;
    wrapDay = 1'b0;
    if (fmt24) begin
      if ({hour.tens, hour.ones} == `RWC_H24_LAST) begin
        next_hour = `RWC_RST_HOUR;
        wrapDay = 1'b1;
      end else if (hour.ones == `RWC_ONES_LAST) begin
        next_hour.ones = 4'h0;
        next_hour.tens = hour.tens + 2'h1;
      end else begin
        next_hour.ones = hour.ones + 4'h1;
      end
    end else begin
      if ({hour.tens, hour.ones} == `RWC_H12_LAST) begin
        next_hour = `RWC_RST_HOUR;
        next_pm = ~pmFlag;
        wrapDay = pmFlag;
      end else if (hour.ones == `RWC_ONES_LAST) begin
        next_hour.ones = 4'h0;
        next_hour.tens = hour.tens + 2'h1;
      end else begin
        next_hour.ones = hour.ones + 4'h1;
      end
    end
  end

  // hour register: clear, then software write, then count
  always_ff @(posedge clk_sys) begin
    if (!rst_n || clearBit) begin
      hour <= `RWC_RST_HOUR;
    end else if (wrEn && hitHour) begin
      hour.tens <= apbReq.pwdata[5:4];
      hour.ones <= apbReq.pwdata[3:0];
    end else if (hourStep) begin
      hour <= next_hour;
    end
  end

  // ----------------------------------------------------------------
  // daily carry and weekday count
  // ----------------------------------------------------------------
  // one-cycle carry out once per day
  always_ff @(posedge clk_sys) begin
    if (!rst_n || clearBit) begin
      dayCarry <= 1'b0;
    end else begin
      dayCarry <= hourStep & wrapDay & ~(wrEn & hitHour); // hour write cancels it
    end
  end

  // weekday advances on the carry, wraps saturday to sunday
  always_ff @(posedge clk_sys) begin
    if (!rst_n || clearBit) begin
      weekday <= `RWC_RST_DAY;
    end else if (wrEn && hitWkday) begin
      if (apbReq.pwdata[2:0] != `RWC_DAY_BAD) begin
        weekday <= apbReq.pwdata[2:0];
      end
    end else if (dayCarry) begin
      if (weekday >= `RWC_DAY_LAST) begin
        weekday <= `RWC_RST_DAY;
      end else begin
        weekday <= weekday + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // clear bit is kept across its own clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clearBit <= 1'b0;
    end else if (wrEn && hitCtrl) begin
      clearBit <= apbReq.pwdata[`RWC_CR_CLR];
    end
  end

  // run, format, reserved bit; all forced low during clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n || clearBit) begin
      runBit <= 1'b0;
      fmt24 <= 1'b0;
      rsvBit <= 1'b0;
    end else if (wrEn && hitCtrl) begin
      runBit <= apbReq.pwdata[`RWC_CR_RUN];
      fmt24 <= apbReq.pwdata[`RWC_CR_FMT];
      rsvBit <= apbReq.pwdata[`RWC_CR_RSV];
    end
  end

  // afternoon flag: written by software, toggled at the 11 wrap
  always_ff @(posedge clk_sys) begin
    if (!rst_n || clearBit) begin
      pmFlag <= 1'b0;
    end else if (wrEn && hitCtrl) begin
      pmFlag <= apbReq.pwdata[`RWC_CR_PM];
    end else if (hourStep && !fmt24) begin
      pmFlag <= next_pm;
    end
  end

  assign runEnable = runBit;
  assign softClear = clearBit;

  // ----------------------------------------------------------------
  // update busy
  // ----------------------------------------------------------------
  // busy stretched for BUSY_CYC cycles from each running count tick
  always_ff @(posedge clk_sys) begin
    if (!rst_n || clearBit) begin
      busyCnt <= 4'h0;
      busy <= 1'b0;
    end else if (countTick && runBit) begin
      busyCnt <= BUSY_CYC;
      busy <= 1'b1;
    end else if (busyCnt > 4'h1) begin
      busyCnt <= busyCnt - 4'h1;
    end else begin
      busyCnt <= 4'h0;
      busy <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // captured in the setup phase, shown in the access phase
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdData <= 32'h0000_0000;
    end else if (setup && !apbReq.pwrite) begin
      rdData <= 32'h0000_0000;
      if (hitHour) begin
        rdData[5:0] <= {hour.tens, hour.ones};
      end else if (hitWkday) begin
        rdData[`RWC_WK_BUSY] <= busy;
        rdData[2:0] <= weekday;
      end else if (hitCtrl) begin
        rdData[`RWC_CR_RUN] <= runBit;
        rdData[`RWC_CR_FMT] <= fmt24;
        rdData[`RWC_CR_PM] <= pmFlag;
        rdData[`RWC_CR_CLR] <= clearBit;
        rdData[`RWC_CR_RSV] <= rsvBit;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence hourWrite;
    wrEn && hitHour;
  endsequence

  sequence stepAtEleven;
    hourStep && !fmt24 && ({hour.tens, hour.ones} == `RWC_H12_LAST)
      && !(wrEn && hitCtrl) && !(wrEn && hitHour);
  endsequence

  sequence dayStep;
    dayCarry && !clearBit && !(wrEn && hitWkday);
  endsequence

  weekday_range_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    weekday <= `RWC_DAY_LAST) else $error("weekday out of range");

  weekday_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dayStep |=> weekday == (($past(weekday) == `RWC_DAY_LAST) ? 3'h0 : $past(weekday) + 3'h1))
    else $error("weekday did not advance on day carry");

  busy_window_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (countTick && runBit && !clearBit) |=> busy [*4])
    else $error("busy not held after count tick");

  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (access && !apbReq.pwrite && (hitWkday || hitCtrl)) |->
      (apbRsp.prdata[6:3] == 4'h0 || hitCtrl) && (apbRsp.prdata[2:0] == 3'h0 || hitWkday))
    else $error("reserved bits read nonzero");

  bad_code_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wrEn && hitWkday && apbReq.pwdata[2:0] == `RWC_DAY_BAD && !clearBit) |=> $stable(weekday))
    else $error("prohibited weekday code stored");

  stop_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!runBit && !clearBit && !(wrEn && hitHour)) |=> $stable(hour))
    else $error("hour moved while stopped");

  hour_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (hourWrite and (!clearBit)) |=> hour.ones == $past(apbReq.pwdata[3:0]))
    else $error("hour write lost");

  pm_toggle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stepAtEleven |=> (pmFlag != $past(pmFlag)) && (hour == `RWC_RST_HOUR))
    else $error("afternoon flag not toggled at wrap");

  tens_range_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (hourStep && !(wrEn && hitHour)) |=> hour.tens <= `RWC_TENS_LAST)
    else $error("hour tens beyond two");

  clear_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clearBit |=> (hour == `RWC_RST_HOUR) && (weekday == 3'h0) && !runBit && !pmFlag)
    else $error("clear did not zero state");

  // ----------------------------------------------------------------
  // count, wrap and read-back checks
  // ----------------------------------------------------------------
  // a day-ending wrap that no hour write overrides gives one carry
  day_carry_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (hourStep && wrapDay && !(wrEn && hitHour)) |=> dayCarry)
    else $error("day carry missing after wrap");

  // 24-hour count returns to zero after twenty-three
  h24_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (hourStep && fmt24 && !(wrEn && hitHour) && ({hour.tens, hour.ones} == `RWC_H24_LAST))
      |=> (hour == `RWC_RST_HOUR))
    else $error("24-hour count did not wrap");

  // 12-hour count never passes eleven by counting
  h12_range_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (hourStep && !fmt24 && !(wrEn && hitHour) && ({hour.tens, hour.ones} < `RWC_H12_LAST))
      |=> ({hour.tens, hour.ones} <= `RWC_H12_LAST))
    else $error("12-hour count beyond eleven");

  // bcd ones digit stays a decimal digit while counting
  ones_range_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (hourStep && !(wrEn && hitHour) && (hour.ones <= `RWC_ONES_LAST))
      |=> (hour.ones <= `RWC_ONES_LAST))
    else $error("hour ones digit beyond nine");

  // busy flag read back as it stood at the setup edge
  busy_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (setup && !apbReq.pwrite && hitWkday) |=> (apbRsp.prdata[`RWC_WK_BUSY] == $past(busy)))
    else $error("busy flag not shown on read");

  // a stopped clock raises no busy window
  stop_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!runBit && !busy) |=> !busy)
    else $error("busy raised while stopped");

  // weekday holds while stopped unless written or a late carry lands
  weekday_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!runBit && !clearBit && !dayCarry && !(wrEn && hitWkday))
      |=> $stable(weekday))
    else $error("weekday moved while stopped");

  // clear also drops busy, carry and the format bit
  clear_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clearBit |=> (!busy && !dayCarry && !fmt24))
    else $error("clear left busy, carry or format set");

endmodule

// [rtc_wkday_pkg.sv]
package rwc_pkg;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rwc_apb_req_type;

  // apb answer to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rwc_apb_rsp_type;

  // bcd hour count
  typedef struct packed {
    logic [1:0] tens;
    logic [3:0] ones;
  } rwc_hour_type;

endpackage
